/* File: logic/capture_seq_pkg.sv */
package capture_seq_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STAT_ADDR = 8'h04;
    localparam logic [7:0] ID_ADDR = 8'h08;

    // control register fields
    localparam int CTRL_FIELD1_BIT = 0;
    localparam int CTRL_FIELD2_BIT = 1;
    localparam int CTRL_FRAME_BIT = 2;
    localparam int CTRL_CONT_BIT = 3;
    localparam int CTRL_ON_BIT = 4;
    localparam int CTRL_IRQ_EN_BIT = 5;
    localparam int CTRL_WIDTH = 6;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // status register fields
    localparam int STAT_F1_DONE_BIT = 0;
    localparam int STAT_F2_DONE_BIT = 1;
    localparam int STAT_FRM_DONE_BIT = 2;
    localparam int STAT_CMPL_BIT = 3;
    localparam int STAT_HALT_BIT = 4;
    localparam int STAT_CAPT_BIT = 5;
    localparam int STAT_FIELD_BIT = 6;

    // arbitrary value, identifies nothing
    localparam logic [31:0] BLOCK_ID = 32'h0000_0C5E;

    // ****************************************
    // video side
    // ****************************************
    localparam int DATA_WIDTH = 8;
    localparam int SYNC_WIDTH = 12;

    // selection codes {continuous, frame, field2, field1}
    localparam logic [3:0] SEL_NC_F1 = 4'h1;
    localparam logic [3:0] SEL_NC_F2 = 4'h2;
    localparam logic [3:0] SEL_NC_BOTH = 4'h3;
    localparam logic [3:0] SEL_NC_FRAME = 4'h4;
    localparam logic [3:0] SEL_NC_PROG = 4'h5;
    localparam logic [3:0] SEL_SINGLE = 4'h7;
    localparam logic [3:0] SEL_C_F1 = 4'h9;
    localparam logic [3:0] SEL_C_F2 = 4'hA;
    localparam logic [3:0] SEL_C_FRAME = 4'hC;
    localparam logic [3:0] SEL_C_PROG = 4'hD;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CAPT = 3'b010,
        ST_SKIP = 3'b100
    } seq_state_type;

endpackage

/* File: logic/pin_sync.sv */
`timescale 1ns/100ps

// two-stage synchroniser for a group of pin inputs
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage feeds only the second
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= pin_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule

/* File: logic/video_capture_field_sequencer.sv */
`timescale 1ns/100ps

module video_capture_field_sequencer (
    input wire logic clock_i,
    input wire logic rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // video source pins
    input wire logic vid_field_start_i,
    input wire logic vid_field_end_i,
    input wire logic vid_field2_i,
    input wire logic vid_sample_valid_i,
    input wire logic [7:0] vid_data_i,
    // capture buffer write side
    output logic buf_wr_o,
    output logic [7:0] buf_data_o,
    output logic capture_active_o,
    output logic capture_irq_o
);

    // ****************************************
    // pin synchronisation
    // ****************************************
    logic [capture_seq_pkg::SYNC_WIDTH-1:0] pins_sync;
    logic start_s;
    logic end_s;
    logic field2_s;
    logic valid_s;
    logic [7:0] data_s;
    logic start_d_ff;
    logic end_d_ff;
    logic start_pulse;
    logic end_pulse;

    pin_sync #(
        .WIDTH(capture_seq_pkg::SYNC_WIDTH)
    ) u_pin_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .pin_i({vid_field_start_i, vid_field_end_i, vid_field2_i, vid_sample_valid_i, vid_data_i}),
        .sync_o(pins_sync)
    );

    // split the synchronised pin group back into its parts
    assign start_s = pins_sync[11];
    assign end_s = pins_sync[10];
    assign field2_s = pins_sync[9];
    assign valid_s = pins_sync[8];
    assign data_s = pins_sync[7:0];

    // rising edges of field start and field end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            start_d_ff <= 1'b0;
            end_d_ff <= 1'b0;
        end else begin
            start_d_ff <= start_s;
            end_d_ff <= end_s;
        end
    end

    // one-cycle pulses; the delay flops reset to the idle pin level,
    // so leaving reset never fakes a field start or end
    assign start_pulse = start_s & ~start_d_ff;
    assign end_pulse = end_s & ~end_d_ff;

    // ****************************************
    // apb register access
    // ****************************************
    logic [capture_seq_pkg::CTRL_WIDTH-1:0] ctrl_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic access;
    logic wr_ctrl;
    logic wr_stat;
    logic addr_ok;
    logic [3:0] sel;
    logic chan_on;
    logic irq_en;

    // transfer completes on the edge where pready is seen high
    assign access = psel_i & penable_i & pready_ff;
    assign addr_ok = (paddr_i == capture_seq_pkg::CTRL_ADDR) | (paddr_i == capture_seq_pkg::STAT_ADDR) |
        (paddr_i == capture_seq_pkg::ID_ADDR);
    assign wr_ctrl = access & pwrite_i & (paddr_i == capture_seq_pkg::CTRL_ADDR);
    assign wr_stat = access & pwrite_i & (paddr_i == capture_seq_pkg::STAT_ADDR);

    assign sel = ctrl_ff[capture_seq_pkg::CTRL_CONT_BIT:capture_seq_pkg::CTRL_FIELD1_BIT];
    assign chan_on = ctrl_ff[capture_seq_pkg::CTRL_ON_BIT];
    assign irq_en = ctrl_ff[capture_seq_pkg::CTRL_IRQ_EN_BIT];

    // one wait state: pready rises on the second access cycle
    // pready is a pulse, so a request still held cannot complete on two edges in a row
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= psel_i & penable_i & ~pready_ff;
            pslverr_ff <= psel_i & penable_i & ~pready_ff & ~addr_ok;
        end
    end

    // control register
    // best changed between fields: flags follow the selection seen at field end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_ff <= capture_seq_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_ff <= pwdata_i[capture_seq_pkg::CTRL_WIDTH-1:0];
        end
    end

    // ****************************************
    // field sequencer
    // ****************************************
    capture_seq_pkg::seq_state_type state_ff;
    capture_seq_pkg::seq_state_type nxt_state;
    logic f1_done_ff;
    logic f2_done_ff;
    logic frm_done_ff;
    logic cmpl_ff;
    logic halt_ff;
    logic nxt_halt;
    // frame_open_ff: a field 2 belongs to a frame only after its field 1 was taken
    logic frame_open_ff;
    logic nxt_frame_open;
    logic field2_ff;
    logic want;
    logic set_f1;
    logic set_f2;
    logic set_frm;
    logic set_cmpl;
    logic in_capt;

    // capturing state, gates buffer writes and status
    assign in_capt = (state_ff == capture_seq_pkg::ST_CAPT);

    // does the field now starting get captured
    // a refused field runs through skip, so its samples never reach the buffer
    always_comb begin
        want = 1'b0;
        case (sel)
            capture_seq_pkg::SEL_NC_F1: want = ~field2_s & ~f1_done_ff;
            capture_seq_pkg::SEL_NC_F2: want = field2_s & ~f2_done_ff;
            capture_seq_pkg::SEL_NC_BOTH: want = field2_s ? ~f2_done_ff : ~f1_done_ff;
            capture_seq_pkg::SEL_NC_FRAME: want = field2_s ? frame_open_ff : (~halt_ff | ~frm_done_ff);
            capture_seq_pkg::SEL_NC_PROG: want = ~field2_s & (~halt_ff | ~frm_done_ff);
            capture_seq_pkg::SEL_SINGLE: want = field2_s ? frame_open_ff : ~frm_done_ff;
            capture_seq_pkg::SEL_C_F1: want = ~field2_s;
            capture_seq_pkg::SEL_C_F2: want = field2_s;
            capture_seq_pkg::SEL_C_FRAME: want = 1'b1;
            capture_seq_pkg::SEL_C_PROG: want = ~field2_s;
            default: want = 1'b0;
        endcase
        want = want & chan_on;
    end

    // state and halt decisions at field boundaries
    always_comb begin
        nxt_state = state_ff;
        nxt_halt = halt_ff;
        nxt_frame_open = frame_open_ff;
        case (state_ff)
            capture_seq_pkg::ST_IDLE, capture_seq_pkg::ST_SKIP: begin
                if (start_pulse) begin
                    nxt_state = want ? capture_seq_pkg::ST_CAPT : capture_seq_pkg::ST_SKIP;
                    if (want && !field2_s) begin
                        nxt_halt = 1'b0;
                        nxt_frame_open = 1'b1;
                    end else if (!field2_s) begin
                        nxt_frame_open = 1'b0;
                    end
                end else if (end_pulse) begin
                    nxt_state = capture_seq_pkg::ST_IDLE;
                end
            end
            capture_seq_pkg::ST_CAPT: begin
                if (end_pulse) begin
                    nxt_state = capture_seq_pkg::ST_IDLE;
                    // non-continuous frame and progressive modes halt if the previous frame flag is still set
                    if ((sel == capture_seq_pkg::SEL_NC_FRAME) && field2_ff && frm_done_ff) begin
                        nxt_halt = 1'b1;
                    end
                    if ((sel == capture_seq_pkg::SEL_NC_PROG) && !field2_ff && frm_done_ff) begin
                        nxt_halt = 1'b1;
                    end
                    if (field2_ff) begin
                        nxt_frame_open = 1'b0;
                    end
                end else if (start_pulse) begin
                    nxt_state = want ? capture_seq_pkg::ST_CAPT : capture_seq_pkg::ST_SKIP;
                end
            end
            default: begin
                nxt_state = capture_seq_pkg::ST_IDLE;
            end
        endcase
    end

    // sequencer registers; field id latched at each field start
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= capture_seq_pkg::ST_IDLE;
            halt_ff <= 1'b0;
            frame_open_ff <= 1'b0;
            field2_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            halt_ff <= nxt_halt;
            frame_open_ff <= nxt_frame_open;
            if (start_pulse) begin
                field2_ff <= field2_s;
            end
        end
    end

    // ****************************************
    // completion flags
    // ****************************************
    // flag to set at the end of a captured field
    always_comb begin
        set_f1 = 1'b0;
        set_f2 = 1'b0;
        set_frm = 1'b0;
        if (in_capt && end_pulse) begin
            case (sel)
                capture_seq_pkg::SEL_NC_F1, capture_seq_pkg::SEL_C_F1: set_f1 = ~field2_ff;
                capture_seq_pkg::SEL_NC_F2, capture_seq_pkg::SEL_C_F2: set_f2 = field2_ff;
                capture_seq_pkg::SEL_NC_BOTH: begin
                    set_f1 = ~field2_ff;
                    set_f2 = field2_ff;
                end
                capture_seq_pkg::SEL_NC_FRAME, capture_seq_pkg::SEL_SINGLE,
                capture_seq_pkg::SEL_C_FRAME: set_frm = field2_ff;
                capture_seq_pkg::SEL_NC_PROG, capture_seq_pkg::SEL_C_PROG: set_frm = ~field2_ff;
                default: set_frm = 1'b0;
            endcase
        end
        set_cmpl = set_f1 | set_f2 | set_frm;
    end

    // sticky flags, write one to clear, a set wins over a clear
    // so a field ending during a clear is never lost
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            f1_done_ff <= 1'b0;
            f2_done_ff <= 1'b0;
            frm_done_ff <= 1'b0;
            cmpl_ff <= 1'b0;
        end else begin
            f1_done_ff <= set_f1 | (f1_done_ff & ~(wr_stat & pwdata_i[capture_seq_pkg::STAT_F1_DONE_BIT]));
            f2_done_ff <= set_f2 | (f2_done_ff & ~(wr_stat & pwdata_i[capture_seq_pkg::STAT_F2_DONE_BIT]));
            frm_done_ff <= set_frm | (frm_done_ff & ~(wr_stat & pwdata_i[capture_seq_pkg::STAT_FRM_DONE_BIT]));
            cmpl_ff <= set_cmpl | (cmpl_ff & ~(wr_stat & pwdata_i[capture_seq_pkg::STAT_CMPL_BIT]));
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // only samples of a captured field reach the buffer
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            buf_wr_o <= 1'b0;
            buf_data_o <= 8'h00;
            capture_active_o <= 1'b0;
        end else begin
            buf_wr_o <= in_capt & valid_s & chan_on;
            buf_data_o <= data_s;
            capture_active_o <= (nxt_state == capture_seq_pkg::ST_CAPT);
        end
    end

    // complete flag gated by its enable
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            capture_irq_o <= 1'b0;
        end else begin
            capture_irq_o <= (set_cmpl | cmpl_ff) & irq_en;
        end
    end

    // read data
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        case (paddr_i)
            capture_seq_pkg::CTRL_ADDR: nxt_prdata[capture_seq_pkg::CTRL_WIDTH-1:0] = ctrl_ff;
            capture_seq_pkg::STAT_ADDR: begin
                nxt_prdata[capture_seq_pkg::STAT_F1_DONE_BIT] = f1_done_ff;
                nxt_prdata[capture_seq_pkg::STAT_F2_DONE_BIT] = f2_done_ff;
                nxt_prdata[capture_seq_pkg::STAT_FRM_DONE_BIT] = frm_done_ff;
                nxt_prdata[capture_seq_pkg::STAT_CMPL_BIT] = cmpl_ff;
                nxt_prdata[capture_seq_pkg::STAT_HALT_BIT] = halt_ff;
                nxt_prdata[capture_seq_pkg::STAT_CAPT_BIT] = in_capt;
                nxt_prdata[capture_seq_pkg::STAT_FIELD_BIT] = field2_ff;
            end
            capture_seq_pkg::ID_ADDR: nxt_prdata = capture_seq_pkg::BLOCK_ID;
            default: nxt_prdata = 32'h0000_0000;
        endcase
    end

    // read data latched in the first access cycle, held while pready is high
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel_i && penable_i && !pready_ff && !pwrite_i) begin
            prdata_ff <= nxt_prdata;
        end
    end

    // bus outputs straight from their registers
    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;

endmodule

/* File: test/capture_seq_props.sv */
`timescale 1ns/100ps

// ****************************************
// port checker
// ****************************************
module capture_seq_props (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic vid_field_start_i,
    input wire logic vid_field_end_i,
    input wire logic vid_field2_i,
    input wire logic vid_sample_valid_i,
    input wire logic [7:0] vid_data_i,
    input wire logic buf_wr_o,
    input wire logic [7:0] buf_data_o,
    input wire logic capture_active_o,
    input wire logic capture_irq_o
);
    logic [5:0] ctrl_ff;
    logic ch_on;
    logic irq_en;
    logic rsv;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // shadow of the control register, updated on the completing edge
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_ff <= 6'h00;
        end else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == capture_seq_pkg::CTRL_ADDR) begin
            ctrl_ff <= pwdata_i[5:0];
        end
    end
    // decoded control fields
    assign ch_on = ctrl_ff[capture_seq_pkg::CTRL_ON_BIT];
    assign irq_en = ctrl_ff[capture_seq_pkg::CTRL_IRQ_EN_BIT];
    assign rsv = ctrl_ff[3:0] inside {4'h0, 4'h6, 4'h8, 4'hB, 4'hE, 4'hF};

    a_ready_wait: assert property ($rose(penable_i) && psel_i |=> pready_o ##1 !pready_o)
        else $error("access not ended by one wait state pulse");
    a_err_unmapped: assert property (
        pready_o && !pwrite_i && paddr_i > 8'h08 |-> pslverr_o && prdata_o == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_irq_gated: assert property (!irq_en && !$past(irq_en) |-> !capture_irq_o)
        else $error("interrupt high while disabled");
    a_off_idle: assert property (!ch_on [*5] |-> !buf_wr_o)
        else $error("sample written while channel off");
    a_reserved_idle: assert property (rsv [*5] |-> !buf_wr_o && !capture_active_o)
        else $error("capture under reserved selection");
    a_sample_path: assert property (
        buf_wr_o |-> $past(vid_sample_valid_i, 3) && buf_data_o == $past(vid_data_i, 3))
        else $error("written sample does not match pin sample");
    a_wr_in_field: assert property (buf_wr_o |-> capture_active_o)
        else $error("sample written outside captured field");
    a_start_delay: assert property (
        $rose(capture_active_o) |-> $past(vid_field_start_i, 3) || $past(vid_field_start_i, 4))
        else $error("capture began without field start");

    c_sample: cover property (buf_wr_o);
    c_irq: cover property (capture_irq_o);
    c_refused: cover property (pready_o && pslverr_o);
endmodule

bind video_capture_field_sequencer capture_seq_props u_props (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .vid_field_start_i, .vid_field_end_i, .vid_field2_i,
    .vid_sample_valid_i, .vid_data_i, .buf_wr_o, .buf_data_o, .capture_active_o, .capture_irq_o);

/* File: test/video_source_model.sv */
`timescale 1ns/100ps

// ****************************************
// video source sending whole fields
// ****************************************
module video_source_model (
    input wire logic clock_i,
    output logic field_start_o,
    output logic field_end_o,
    output logic field2_o,
    output logic valid_o,
    output logic [7:0] data_o
);
    logic [7:0] last = 8'h00;
    // idle pins at time zero
    initial begin
        field_start_o = 1'b0;
        field_end_o = 1'b0;
        field2_o = 1'b0;
        valid_o = 1'b0;
        data_o = 8'hFF;
    end
    // one field: id, start, samples with gap, end, blanking
    task automatic send_field(input logic f2, input int n, input int gap);
        @(posedge clock_i);
        field2_o <= f2;
        @(posedge clock_i);
        field_start_o <= 1'b1;
        @(posedge clock_i);
        field_start_o <= 1'b0;
        repeat (5) @(posedge clock_i);
        for (int i = 0; i < n; i++) begin
            last = 8'h5A + 8'(i * 7) + {7'h00, f2};
            valid_o <= 1'b1;
            data_o <= last;
            @(posedge clock_i);
            if (gap > 0) begin
                valid_o <= 1'b0;
                data_o <= ~last; // no stale sample on the bus
                repeat (gap) @(posedge clock_i);
            end
        end
        valid_o <= 1'b0;
        data_o <= ~last;
        field_end_o <= 1'b1;
        @(posedge clock_i);
        field_end_o <= 1'b0;
        repeat (8) @(posedge clock_i);
    endtask
endmodule

/* File: test/tb_video_capture_field_sequencer.sv */
`timescale 1ns/100ps

module tb_video_capture_field_sequencer;
    logic clock_i;
    logic rst_i;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, vid_field_start_i, vid_field_end_i, vid_field2_i, vid_sample_valid_i;
    logic [7:0] vid_data_i;
    logic buf_wr_o, capture_active_o, capture_irq_o;
    logic [7:0] buf_data_o;
    int mismatches = 0;
    int total_checks = 0;
    int wr_count = 0;
    logic [3:0] rsv [6] = '{4'h0, 4'h6, 4'h8, 4'hB, 4'hE, 4'hF};
    logic [3:0] csel [3] = '{capture_seq_pkg::SEL_C_F1, capture_seq_pkg::SEL_C_F2, capture_seq_pkg::SEL_C_PROG};
    logic cf2 [3] = '{1'b0, 1'b1, 1'b0};
    logic [3:0] cst [3] = '{4'h9, 4'hA, 4'hC};

    video_capture_field_sequencer DUT (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .vid_field_start_i, .vid_field_end_i, .vid_field2_i,
        .vid_sample_valid_i, .vid_data_i, .buf_wr_o, .buf_data_o, .capture_active_o, .capture_irq_o);
    video_source_model src (.clock_i(clock_i), .field_start_o(vid_field_start_i), .field_end_o(vid_field_end_i),
        .field2_o(vid_field2_i), .valid_o(vid_sample_valid_i), .data_o(vid_data_i));

    // ****************************************
    // clock, sample counter, watchdog
    // ****************************************
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    // counts every sample written to the buffer
    always @(posedge clock_i) if (buf_wr_o === 1'b1) wr_count <= wr_count + 1;
    // cuts a hang short
    initial begin
        repeat (20000) @(posedge clock_i);
        mismatches++;
        give_verdict();
    end

    task automatic give_verdict();
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do @(posedge clock_i); while (pready_o !== 1'b1);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ex);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q, x);
        chk({31'h0000_0000, e}, {31'h0000_0000, ex});
    endtask
    task automatic mode(input logic [3:0] s);
        wr(capture_seq_pkg::CTRL_ADDR, {26'h000_0000, 2'b11, s});
    endtask
    task automatic clr();
        wr(capture_seq_pkg::STAT_ADDR, 32'h0000_000F);
    endtask
    // one field, then samples written and low status bits
    task automatic step(input logic f2, input logic cap, input logic [3:0] st);
        int c0;
        logic [31:0] q;
        logic e;
        c0 = wr_count;
        src.send_field(f2, 4, f2 ? 0 : 2);
        chk(32'(wr_count - c0), cap ? 32'h0000_0004 : 32'h0000_0000);
        apb(1'b0, capture_seq_pkg::STAT_ADDR, 32'h0000_0000, q, e);
        chk({28'h000_0000, q[3:0]}, {28'h000_0000, st});
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        rst_i = 1'b1;
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        rd(capture_seq_pkg::CTRL_ADDR, 32'h0000_0000, 1'b0);
        rd(capture_seq_pkg::STAT_ADDR, 32'h0000_0000, 1'b0);
        wr(capture_seq_pkg::ID_ADDR, 32'hFFFF_FFFF);
        rd(capture_seq_pkg::ID_ADDR, capture_seq_pkg::BLOCK_ID, 1'b0);
        rd(8'h0C, 32'h0000_0000, 1'b1);
        wr(capture_seq_pkg::CTRL_ADDR, {26'h000_0000, 2'b10, capture_seq_pkg::SEL_C_F1});
        step(1'b0, 1'b0, 4'h0);
        mode(capture_seq_pkg::SEL_NC_F1);
        step(1'b0, 1'b1, 4'h9);
        step(1'b1, 1'b0, 4'h9);
        step(1'b0, 1'b0, 4'h9);
        clr();
        step(1'b0, 1'b1, 4'h9);
        clr();
        step(1'b0, 1'b1, 4'h9);
        clr();
        mode(capture_seq_pkg::SEL_NC_F2);
        step(1'b1, 1'b1, 4'hA);
        step(1'b0, 1'b0, 4'hA);
        step(1'b1, 1'b0, 4'hA);
        clr();
        step(1'b1, 1'b1, 4'hA);
        clr();
        mode(capture_seq_pkg::SEL_NC_BOTH);
        step(1'b0, 1'b1, 4'h9);
        step(1'b1, 1'b1, 4'hB);
        wr(capture_seq_pkg::STAT_ADDR, 32'h0000_0002);
        step(1'b0, 1'b0, 4'h9);
        step(1'b1, 1'b1, 4'hB);
        clr();
        mode(capture_seq_pkg::SEL_SINGLE);
        step(1'b0, 1'b1, 4'h0);
        step(1'b1, 1'b1, 4'hC);
        step(1'b0, 1'b0, 4'hC);
        step(1'b1, 1'b0, 4'hC);
        clr();
        step(1'b0, 1'b1, 4'h0);
        step(1'b1, 1'b1, 4'hC);
        clr();
        mode(capture_seq_pkg::SEL_NC_FRAME);
        step(1'b0, 1'b1, 4'h0);
        step(1'b1, 1'b1, 4'hC);
        step(1'b0, 1'b1, 4'hC);
        step(1'b1, 1'b1, 4'hC);
        step(1'b0, 1'b0, 4'hC);
        rd(capture_seq_pkg::STAT_ADDR, 32'h0000_001C, 1'b0);
        step(1'b1, 1'b0, 4'hC);
        clr();
        step(1'b0, 1'b1, 4'h0);
        step(1'b1, 1'b1, 4'hC);
        clr();
        mode(capture_seq_pkg::SEL_NC_PROG);
        step(1'b0, 1'b1, 4'hC);
        step(1'b0, 1'b1, 4'hC);
        step(1'b0, 1'b0, 4'hC);
        clr();
        step(1'b0, 1'b1, 4'hC);
        clr();
        for (int i = 0; i < 3; i++) begin
            mode(csel[i]);
            step(cf2[i], 1'b1, cst[i]);
            step(cf2[i], 1'b1, cst[i]);
            clr();
        end
        mode(capture_seq_pkg::SEL_C_FRAME);
        step(1'b0, 1'b1, 4'h0);
        step(1'b1, 1'b1, 4'hC);
        step(1'b0, 1'b1, 4'hC);
        step(1'b1, 1'b1, 4'hC);
        chk({31'h0000_0000, capture_irq_o}, 32'h0000_0001);
        wr(capture_seq_pkg::CTRL_ADDR, {26'h000_0000, 2'b01, capture_seq_pkg::SEL_C_FRAME});
        repeat (2) @(posedge clock_i);
        chk({31'h0000_0000, capture_irq_o}, 32'h0000_0000);
        clr();
        foreach (rsv[i]) begin
            mode(rsv[i]);
            step(1'b0, 1'b0, 4'h0);
            step(1'b1, 1'b0, 4'h0);
        end
        // reset in mid-run clears flags, halt, field id and control
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        rd(capture_seq_pkg::STAT_ADDR, 32'h0000_0000, 1'b0);
        rd(capture_seq_pkg::CTRL_ADDR, 32'h0000_0000, 1'b0);
        give_verdict();
    end
endmodule
